/* common/mpg_regs.svh */
// Register indices, reset values and field layout constants of the port bank.
`ifndef MPG_REGS_SVH
`define MPG_REGS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define MPG_IDX_DIR0   16'hff20
`define MPG_IDX_DIR1   16'hff21
`define MPG_IDX_DIR2   16'hff22
`define MPG_IDX_DIR3   16'hff23
`define MPG_IDX_DIR4   16'hff24
`define MPG_IDX_DIR6   16'hff26
`define MPG_IDX_DAT0   16'hff00
`define MPG_IDX_DAT1   16'hff01
`define MPG_IDX_DAT2   16'hff02
`define MPG_IDX_DAT3   16'hff03
`define MPG_IDX_DAT4   16'hff04
`define MPG_IDX_DAT6   16'hff06
`define MPG_IDX_PUL0   16'hff30
`define MPG_IDX_PUL1   16'hff31
`define MPG_IDX_PUL3   16'hff33
`define MPG_IDX_PUL4   16'hff34
`define MPG_IDX_ANCFG  16'hff40
`define MPG_IDX_CHSEL  16'hff41

// ************************************************************
// Address field and reset values
// ************************************************************
`define MPG_IDX_MSB    17
`define MPG_IDX_LSB    2
`define MPG_DIR_RST    8'hff
`define MPG_DAT_RST    8'h00
`define MPG_PU_RST     8'h00
`define MPG_ANCFG_RST  8'hff
`define MPG_CHSEL_RST  3'h0

// ************************************************************
// Input synchroniser bit positions
// ************************************************************
`define MPG_SY_P0_LSB  0
`define MPG_SY_P1_LSB  4
`define MPG_SY_P2_LSB  12
`define MPG_SY_P3_LSB  20
`define MPG_SY_P4_LSB  24
`define MPG_SY_P6_LSB  26
`define MPG_SY_W       30

`endif

/* common/mpg_pkg.sv */
// Types shared by the port bank design.
package mpg_pkg;

    // ************************************************************
    // Whole state of the port bank
    // ************************************************************
    typedef struct packed {
        logic [3:0]  dir0;
        logic [3:0]  pul0;
        logic [3:0]  dat0;
        logic [7:0]  dir1;
        logic [7:0]  pul1;
        logic [7:0]  dat1;
        logic [7:0]  dir2;
        logic [7:0]  dat2;
        logic [7:0]  ancfg;
        logic [2:0]  chsel;
        logic [3:0]  dir3;
        logic [3:0]  pul3;
        logic [3:0]  dat3;
        logic [1:0]  dir4;
        logic [1:0]  pul4;
        logic [1:0]  dat4;
        logic [3:0]  dir6;
        logic [3:0]  dat6;
        logic [29:0] sync1;
        logic [29:0] sync2;
        logic        wr_pend;
        logic [15:0] wr_idx;
        logic [31:0] rdata;
        logic        ready;
        logic [3:0]  p0_out;
        logic [3:0]  p0_oe;
        logic [3:0]  p0_pu;
        logic [7:0]  p1_out;
        logic [7:0]  p1_oe;
        logic [7:0]  p1_pu;
        logic [7:0]  p2_out;
        logic [7:0]  p2_oe;
        logic [7:0]  p2_conv;
        logic [3:0]  p3_out;
        logic [3:0]  p3_oe;
        logic [3:0]  p3_pu;
        logic [1:0]  p4_out;
        logic [1:0]  p4_oe;
        logic [1:0]  p4_pu;
        logic [3:0]  p6_out;
        logic [3:0]  p6_oe;
    } mpg_state_t;

endpackage : mpg_pkg

/* core/mpg_bank.sv */
// Multi-port general-purpose I/O bank with an AHB-Lite register slave.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`include "mpg_regs.svh"

// Overview of operation
// - Port 0: four bits, latch, direction, pull-ups.
// - Port 1: eight bits, latch, direction, pull-ups.
// - Port 2: eight bits, no pull-up, analog shared.
// - Port 3: four bits, latch, direction, pull-ups.
// - Port 4: two bits, latch, direction, pull-ups.
// - Port 6: four bits, latch, direction, no pull-up.
// - Port 6 output only drives low.
// - Reset puts ports 0,1,3,4,6 in input.
// - Reset makes all port 2 pins analog.
// - Analog input converted only when channel selected.
// - Mode bit zero is output, one is input.
// - Data read: pin if input, latch if output.
// - Reset: mode registers all ones, data zero.
module mpg_bank
    import mpg_pkg::*;
(
    // Clock, reset and clock enable
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Port 0
    input  wire logic [3:0]  p0_in_i,
    output logic      [3:0]  p0_out_o,
    output logic      [3:0]  p0_oe_o,
    output logic      [3:0]  p0_pu_o,
    // Port 1
    input  wire logic [7:0]  p1_in_i,
    output logic      [7:0]  p1_out_o,
    output logic      [7:0]  p1_oe_o,
    output logic      [7:0]  p1_pu_o,
    // Port 2 with converter channel select
    input  wire logic [7:0]  p2_in_i,
    output logic      [7:0]  p2_out_o,
    output logic      [7:0]  p2_oe_o,
    output logic      [7:0]  p2_conv_o,
    // Port 3
    input  wire logic [3:0]  p3_in_i,
    output logic      [3:0]  p3_out_o,
    output logic      [3:0]  p3_oe_o,
    output logic      [3:0]  p3_pu_o,
    // Port 4
    input  wire logic [1:0]  p4_in_i,
    output logic      [1:0]  p4_out_o,
    output logic      [1:0]  p4_oe_o,
    output logic      [1:0]  p4_pu_o,
    // Port 6, open drain
    input  wire logic [3:0]  p6_in_i,
    output logic      [3:0]  p6_out_o,
    output logic      [3:0]  p6_oe_o
);

    // ************************************************************
    // State
    // ************************************************************
    mpg_state_t s;
    mpg_state_t next_s;
    logic       acc;
    logic [15:0] a_idx;

    assign acc   = hsel_i & htrans_i[1] & hready_i;
    assign a_idx = haddr_i[`MPG_IDX_MSB:`MPG_IDX_LSB];

    // ************************************************************
    // Register read multiplexer
    // ************************************************************
    function automatic logic [31:0] rd_mux(input mpg_state_t st, input logic [15:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `MPG_IDX_DIR0: v = {4'hf, st.dir0};
            `MPG_IDX_DIR1: v = st.dir1;
            `MPG_IDX_DIR2: v = st.dir2;
            `MPG_IDX_DIR3: v = {4'hf, st.dir3};
            `MPG_IDX_DIR4: v = {6'h3f, st.dir4};
            `MPG_IDX_DIR6: v = {4'hf, st.dir6};
            // Input bits show the synchronised pin, output bits the latch.
            `MPG_IDX_DAT0: v = {4'h0, (st.dir0 & st.sync2[`MPG_SY_P0_LSB +: 4]) | (~st.dir0 & st.dat0)};
            `MPG_IDX_DAT1: v = (st.dir1 & st.sync2[`MPG_SY_P1_LSB +: 8]) | (~st.dir1 & st.dat1);
            // Analog input pins have no digital input path and read as zero.
            `MPG_IDX_DAT2: v = (st.dir2 & ~st.ancfg & st.sync2[`MPG_SY_P2_LSB +: 8]) | (~st.dir2 & st.dat2);
            `MPG_IDX_DAT3: v = {4'h0, (st.dir3 & st.sync2[`MPG_SY_P3_LSB +: 4]) | (~st.dir3 & st.dat3)};
            `MPG_IDX_DAT4: v = {6'h00, (st.dir4 & st.sync2[`MPG_SY_P4_LSB +: 2]) | (~st.dir4 & st.dat4)};
            `MPG_IDX_DAT6: v = {4'h0, (st.dir6 & st.sync2[`MPG_SY_P6_LSB +: 4]) | (~st.dir6 & st.dat6)};
            `MPG_IDX_PUL0:  v = {4'h0, st.pul0};
            `MPG_IDX_PUL1:  v = st.pul1;
            `MPG_IDX_PUL3:  v = {4'h0, st.pul3};
            `MPG_IDX_PUL4:  v = {6'h00, st.pul4};
            `MPG_IDX_ANCFG: v = st.ancfg;
            `MPG_IDX_CHSEL: v = {5'h00, st.chsel};
            default:       v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction : rd_mux

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        // Only the second stage is read by any logic.
        next_s.sync1 = {p6_in_i, p4_in_i, p3_in_i, p2_in_i, p1_in_i, p0_in_i};
        next_s.sync2 = s.sync1;
        // Write data arrives in the data phase, one cycle after the address.
        if (s.wr_pend) begin
            case (s.wr_idx)
                `MPG_IDX_DIR0: next_s.dir0 = hwdata_i[3:0];
                `MPG_IDX_DIR1: next_s.dir1 = hwdata_i[7:0];
                `MPG_IDX_DIR2: next_s.dir2 = hwdata_i[7:0];
                `MPG_IDX_DIR3: next_s.dir3 = hwdata_i[3:0];
                `MPG_IDX_DIR4: next_s.dir4 = hwdata_i[1:0];
                `MPG_IDX_DIR6: next_s.dir6 = hwdata_i[3:0];
                `MPG_IDX_DAT0: next_s.dat0 = hwdata_i[3:0];
                `MPG_IDX_DAT1: next_s.dat1 = hwdata_i[7:0];
                `MPG_IDX_DAT2: next_s.dat2 = hwdata_i[7:0];
                `MPG_IDX_DAT3: next_s.dat3 = hwdata_i[3:0];
                `MPG_IDX_DAT4: next_s.dat4 = hwdata_i[1:0];
                `MPG_IDX_DAT6: next_s.dat6 = hwdata_i[3:0];
                `MPG_IDX_PUL0:  next_s.pul0  = hwdata_i[3:0];
                `MPG_IDX_PUL1:  next_s.pul1  = hwdata_i[7:0];
                `MPG_IDX_PUL3:  next_s.pul3  = hwdata_i[3:0];
                `MPG_IDX_PUL4:  next_s.pul4  = hwdata_i[1:0];
                `MPG_IDX_ANCFG: next_s.ancfg = hwdata_i[7:0];
                `MPG_IDX_CHSEL: next_s.chsel = hwdata_i[2:0];
                default: begin
                end
            endcase
        end
        next_s.wr_pend = acc & hwrite_i;
        next_s.wr_idx  = a_idx;
        // Read data is fetched in the address phase, so the slave never stalls.
        next_s.rdata   = (acc & ~hwrite_i) ? rd_mux(s, a_idx) : 32'h00000000;
        next_s.ready   = 1'b1;
        // Pins follow the new register values at the same edge.
        next_s.p0_out  = next_s.dat0;
        next_s.p0_oe   = ~next_s.dir0;
        next_s.p0_pu   = next_s.pul0 & next_s.dir0;
        next_s.p1_out  = next_s.dat1;
        next_s.p1_oe   = ~next_s.dir1;
        next_s.p1_pu   = next_s.pul1 & next_s.dir1;
        next_s.p2_out  = next_s.dat2;
        // An analog pin never drives, so the prohibited analog output case stays harmless.
        next_s.p2_oe   = ~next_s.dir2 & ~next_s.ancfg;
        next_s.p2_conv = next_s.ancfg & next_s.dir2 & (8'h01 << next_s.chsel);
        next_s.p3_out  = next_s.dat3;
        next_s.p3_oe   = ~next_s.dir3;
        next_s.p3_pu   = next_s.pul3 & next_s.dir3;
        next_s.p4_out  = next_s.dat4;
        next_s.p4_oe   = ~next_s.dir4;
        next_s.p4_pu   = next_s.pul4 & next_s.dir4;
        next_s.p6_out  = 4'h0;
        next_s.p6_oe   = ~next_s.dir6 & ~next_s.dat6;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s       <= '0;
            s.dir0  <= 4'hf;
            s.dir1  <= `MPG_DIR_RST;
            s.dir2  <= `MPG_DIR_RST;
            s.dir3  <= 4'hf;
            s.dir4  <= 2'h3;
            s.dir6  <= 4'hf;
            s.dat1  <= `MPG_DAT_RST;
            s.dat2  <= `MPG_DAT_RST;
            s.pul1  <= `MPG_PU_RST;
            s.ancfg <= `MPG_ANCFG_RST;
            s.chsel <= `MPG_CHSEL_RST;
            s.ready <= 1'b1;
            s.p2_conv <= 8'h01;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hrdata_o    = s.rdata;
    assign hreadyout_o = s.ready;
    assign hresp_o     = 1'b0;
    assign p0_out_o    = s.p0_out;
    assign p0_oe_o     = s.p0_oe;
    assign p0_pu_o     = s.p0_pu;
    assign p1_out_o    = s.p1_out;
    assign p1_oe_o     = s.p1_oe;
    assign p1_pu_o     = s.p1_pu;
    assign p2_out_o    = s.p2_out;
    assign p2_oe_o     = s.p2_oe;
    assign p2_conv_o   = s.p2_conv;
    assign p3_out_o    = s.p3_out;
    assign p3_oe_o     = s.p3_oe;
    assign p3_pu_o     = s.p3_pu;
    assign p4_out_o    = s.p4_out;
    assign p4_oe_o     = s.p4_oe;
    assign p4_pu_o     = s.p4_pu;
    assign p6_out_o    = s.p6_out;
    assign p6_oe_o     = s.p6_oe;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_RST_INPUT: assert property (@(posedge clk_i) $fell(sys_rst_i) |->
        (p0_oe_o == 4'h0 && p1_oe_o == 8'h00 && p3_oe_o == 4'h0 && p4_oe_o == 2'h0 && p6_oe_o == 4'h0))
        else $error("Port driver enabled after reset.");

    AST_RST_ANALOG: assert property (@(posedge clk_i) $fell(sys_rst_i) |->
        (s.ancfg == 8'hff && p2_oe_o == 8'h00))
        else $error("Port 2 not analog after reset.");

    AST_RST_VALUES: assert property (@(posedge clk_i) $fell(sys_rst_i) |->
        (s.dir1 == 8'hff && s.dir2 == 8'hff && s.dat1 == 8'h00 && s.dat0 == 4'h0))
        else $error("Mode or data register reset value wrong.");

    AST_DIR_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && s.wr_pend && s.wr_idx == `MPG_IDX_DIR1) |=> (p1_oe_o == ~$past(hwdata_i[7:0])))
        else $error("Port 1 driver does not follow its mode write.");

    AST_DAT0_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && s.wr_pend && s.wr_idx == `MPG_IDX_DAT0) |=> (p0_out_o == $past(hwdata_i[3:0])))
        else $error("Port 0 latch does not follow its data write.");

    AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (p6_out_o == 4'h0) && ((p6_oe_o & (s.dat6 | s.dir6)) == 4'h0))
        else $error("Port 6 drives high or drives while released.");

    AST_PULLUP_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ((p0_pu_o & p0_oe_o) == 4'h0) && ((p1_pu_o & p1_oe_o) == 8'h00) &&
        ((p3_pu_o & p3_oe_o) == 4'h0) && ((p4_pu_o & p4_oe_o) == 2'h0))
        else $error("Pull-up connected on an output bit.");

    AST_CONV_SEL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $onehot0(p2_conv_o) && ((p2_conv_o & p2_oe_o) == 8'h00) && ((p2_oe_o & s.ancfg) == 8'h00))
        else $error("Port 2 analog pin drives or several channels converted.");

    AST_READ_DAT1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && acc && !hwrite_i && a_idx == `MPG_IDX_DAT1) |=>
        (hrdata_o[7:0] == $past((s.dir1 & s.sync2[11:4]) | (~s.dir1 & s.dat1))))
        else $error("Port 1 read value wrong.");

endmodule : mpg_bank

/* verification/mpg_pad_model.sv */
// Pin pad model standing for the board beside one port.
module mpg_pad_model #(
    parameter int W = 8
) (
    // Design side
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pu_i,
    // Board side
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven bit shows the latch; port 6 offers only a low level here.
    // An undriven bit with its pull-up connected reads high, else the board level wins.
    always_comb begin
        pin_o = (oe_i & out_i) | (~oe_i & (pu_i | ext_i));
    end
endmodule : mpg_pad_model

/* verification/testbench.sv */
// Self-checking bench for the port bank over AHB-Lite.
`include "mpg_regs.svh"
module testbench
    import mpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hready;
    wire  [7:0]  o_out[6];
    wire  [7:0]  o_oe[6];
    wire  [7:0]  o_pu[6];
    wire  [7:0]  pin[6];
    wire  [7:0]  conv;
    logic [7:0]  ext[6];
    logic [7:0]  dir_s[6];
    logic [7:0]  dat_s[6];
    logic [7:0]  pu_s[6];
    logic [7:0]  ancfg_s;
    logic [2:0]  chsel_s;
    logic        rd_ph = 1'b0;
    logic [31:0] q[$];
    int          seed = 32'h634e;
    int          bad_count = 0;
    int          n_checks = 0;
    int          k;
    localparam logic [15:0] DI[6] = '{`MPG_IDX_DIR0, `MPG_IDX_DIR1, `MPG_IDX_DIR2, `MPG_IDX_DIR3, `MPG_IDX_DIR4,
                                      `MPG_IDX_DIR6};
    localparam logic [15:0] DA[6] = '{`MPG_IDX_DAT0, `MPG_IDX_DAT1, `MPG_IDX_DAT2, `MPG_IDX_DAT3, `MPG_IDX_DAT4,
                                      `MPG_IDX_DAT6};
    localparam logic [15:0] PU[6] = '{`MPG_IDX_PUL0, `MPG_IDX_PUL1, 16'h0, `MPG_IDX_PUL3, `MPG_IDX_PUL4, 16'h0};
    localparam logic [7:0]  M[6]  = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'h03, 8'h0f};
    assign o_pu[2] = 8'h00;
    assign o_pu[5] = 8'h00;
    always #2 clk_i = ~clk_i;
    mpg_bank dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
        .p0_in_i(pin[0][3:0]), .p0_out_o(o_out[0][3:0]), .p0_oe_o(o_oe[0][3:0]), .p0_pu_o(o_pu[0][3:0]),
        .p1_in_i(pin[1]), .p1_out_o(o_out[1]), .p1_oe_o(o_oe[1]), .p1_pu_o(o_pu[1]),
        .p2_in_i(pin[2]), .p2_out_o(o_out[2]), .p2_oe_o(o_oe[2]), .p2_conv_o(conv),
        .p3_in_i(pin[3][3:0]), .p3_out_o(o_out[3][3:0]), .p3_oe_o(o_oe[3][3:0]), .p3_pu_o(o_pu[3][3:0]),
        .p4_in_i(pin[4][1:0]), .p4_out_o(o_out[4][1:0]), .p4_oe_o(o_oe[4][1:0]), .p4_pu_o(o_pu[4][1:0]),
        .p6_in_i(pin[5][3:0]), .p6_out_o(o_out[5][3:0]), .p6_oe_o(o_oe[5][3:0]));
    for (genvar g = 0; g < 6; g++) begin : g_pad
        localparam int W = (g == 4) ? 2 : ((g == 1 || g == 2) ? 8 : 4);
        mpg_pad_model #(.W(W)) pad (.out_i(o_out[g][W-1:0]), .oe_i(o_oe[g][W-1:0]), .pu_i(o_pu[g][W-1:0]),
            .ext_i(ext[g][W-1:0]), .pin_o(pin[g][W-1:0]));
    end
    // ************************************************************
    // Expectations and comparisons
    // ************************************************************
    function automatic logic [7:0] e_oe(int p);
        if (p == 5) return ~dir_s[p] & ~dat_s[p] & M[p];
        if (p == 2) return ~dir_s[p] & ~ancfg_s;
        return ~dir_s[p] & M[p];
    endfunction : e_oe
    function automatic logic [7:0] e_pu(int p);
        return (p == 2 || p == 5) ? 8'h00 : pu_s[p] & dir_s[p] & M[p];
    endfunction : e_pu
    function automatic logic [7:0] e_rd(int p);
        logic [7:0] pad;
        logic [7:0] an;
        pad = (e_oe(p) & dat_s[p] & ((p == 5) ? 8'h00 : 8'hff)) | (~e_oe(p) & (e_pu(p) | ext[p]));
        an = (p == 2) ? ancfg_s & dir_s[p] : 8'h00;
        return ((dir_s[p] & pad & ~an) | (~dir_s[p] & dat_s[p])) & M[p];
    endfunction : e_rd
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
        end
    endtask : cmp_rd
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: pins %h, wanted %h", $time, got, exp);
        end
    endtask : cmp_pin
    // Read data is due in the data phase after a taken read address phase.
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_ph <= 1'b0;
        end else begin
            if (rd_ph) cmp_rd(hrdata, q.pop_front());
            rd_ph <= hsel & htrans[1] & ~hwrite & hready & ce_i;
        end
    end
    // ************************************************************
    // Bus and scenario tasks
    // ************************************************************
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {14'h0, idx, 2'h0};
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
    endtask : xfer
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        q.push_back(exp);
        xfer(1'b0, idx, $random(seed));
    endtask : rd
    task automatic chk(int p);
        cmp_pin(o_oe[p] & M[p], e_oe(p));
        cmp_pin(o_pu[p] & M[p], e_pu(p));
        cmp_pin(o_out[p] & M[p], (p == 5) ? 8'h00 : dat_s[p]);
        if (p == 2) cmp_pin(conv, ancfg_s & dir_s[2] & (8'h01 << chsel_s));
    endtask : chk
    task automatic rdall(int p);
        rd(DI[p], {24'h0, dir_s[p]});
        rd(DA[p], {24'h0, e_rd(p)});
        if (PU[p] != 16'h0) rd(PU[p], {24'h0, pu_s[p]});
    endtask : rdall
    task automatic setp(int p, logic [7:0] d, logic [7:0] v, logic [7:0] u);
        xfer(1'b1, DA[p], {24'h0, v});
        dat_s[p] = v & M[p];
        if (PU[p] != 16'h0) begin
            xfer(1'b1, PU[p], {24'h0, u});
            pu_s[p] = u & M[p];
        end
        xfer(1'b1, DI[p], {24'h0, d});
        dir_s[p] = d | ~M[p];
        repeat (4) @(posedge clk_i);
        chk(p);
        rdall(p);
    endtask : setp
    task automatic do_reset();
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int p = 0; p < 6; p++) begin
            dir_s[p] = 8'hff; dat_s[p] = 8'h00; pu_s[p] = 8'h00;
        end
        ancfg_s = 8'hff;
        chsel_s = 3'h0;
        q.delete();
    endtask : do_reset
    task automatic finish_test();
        $display("checks %0d, errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        repeat (50000) @(posedge clk_i);
        bad_count++;
        $display("unexpected at %0t: run timed out", $time);
        finish_test();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        for (int p = 0; p < 6; p++) ext[p] = $random(seed);
        do_reset();
        repeat (4) @(posedge clk_i);
        for (int p = 0; p < 6; p++) begin
            chk(p);
            rdall(p);
        end
        rd(`MPG_IDX_ANCFG, 32'hff);
        rd(`MPG_IDX_CHSEL, 32'h0);
        rdall(1);
        for (int it = 0; it < 4; it++) begin
            for (int p = 0; p < 6; p++) begin
                ext[p] <= $random(seed);
                if (p == 2) begin
                    k = {$random(seed)} % 8;
                    ancfg_s = 8'hff << k;
                    chsel_s = k[2:0];
                    xfer(1'b1, `MPG_IDX_ANCFG, {24'h0, ancfg_s});
                    xfer(1'b1, `MPG_IDX_CHSEL, {29'h0, chsel_s});
                end
                // Analog pins stay inputs, since analog together with output is not allowed.
                setp(p, ((it == 0) ? 8'h00 : (it == 1) ? 8'hff : $random(seed)) | ((p == 2) ? ancfg_s : 8'h00),
                     $random(seed), $random(seed));
            end
        end
        for (int a = 0; a < 8; a++) begin
            chsel_s = a[2:0];
            xfer(1'b1, `MPG_IDX_CHSEL, {29'h0, chsel_s});
            @(posedge clk_i);
            chk(2);
        end
        xfer(1'b1, 16'hff05, 32'hff);
        rd(16'hff05, 32'h0);
        rd(16'hff10, 32'h0);
        ce_i <= 1'b0;
        xfer(1'b1, DA[1], {24'h0, ~dat_s[1]});
        ce_i <= 1'b1;
        rdall(1);
        do_reset();
        repeat (2) @(posedge clk_i);
        for (int p = 0; p < 6; p++) chk(p);
        finish_test();
    end
endmodule : testbench
